// file: stop_clk_pkg.sv
// constants, types and helpers shared by the stop-mode clock and power controller
`default_nettype none
package stop_clk_pkg;
	// register byte offsets on the 32-bit bus
	localparam logic [7:0] ADDR_CLK_CTRL0    = 8'h00;
	localparam logic [7:0] ADDR_CLK_CTRL1    = 8'h04;
	localparam logic [7:0] ADDR_CLK_CTRL2    = 8'h08;
	localparam logic [7:0] ADDR_PROC_MODE2   = 8'h0c;
	localparam logic [7:0] ADDR_PROTECT      = 8'h10;
	localparam logic [7:0] ADDR_WAIT_CMD     = 8'h14;
	localparam logic [7:0] ADDR_POWER_STATUS = 8'h18;
	// field positions
	localparam int BIT_PCLK_OFF_WAIT = 2;
	localparam int BIT_DIV8          = 6;
	localparam int BIT_ALL_OFF       = 0;
	localparam int BIT_CTRL_B        = 1;
	localparam int BIT_DIV_LO        = 6;
	localparam int BIT_DIV_HI        = 7;
	localparam int BIT_DET_EN        = 0;
	localparam int BIT_RING_SEL      = 1;
	localparam int BIT_ACTION        = 7;
	localparam int BIT_LOCK          = 1;
	localparam int BIT_PWR_WE        = 1;
	localparam int BIT_WAIT          = 0;
	// reset values: divide-by-8 from the main clock
	localparam logic RST_DIV8    = 1'h1;
	localparam logic RST_ZERO    = 1'h0;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// oscillator stabilisation time after a stop-mode wake
	localparam int CLK_PERIOD_NS   = 50;
	localparam int OSC_STAB_NS     = 2000;
	localparam int OSC_STAB_CYCLES = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// power modes, gray along normal -> stop -> restart
	typedef enum logic [1:0] {
		MODE_NORMAL  = 2'h0,
		MODE_STOP    = 2'h1,
		MODE_RESTART = 2'h3,
		MODE_WAIT    = 2'h2
	} pmode_t;
	// wake request pins, asynchronous to aclk
	typedef struct packed {
		logic ext_pin_irq;
		logic timer_irq;
		logic serial_irq;
	} wake_in_t;
	// clock and power controls toward the clock tree
	typedef struct packed {
		logic       main_osc_en;
		logic       ring_osc_en;
		logic       cpu_clk_en;
		logic       periph_clk_en;
		logic       cpu_src_ring;
		logic [4:0] cpu_div;
		logic       port_hold;
		logic       irq_vector_go;
		logic       osc_stop_reset;
		logic       osc_stop_irq;
	} clk_out_t;
	// cpu divider ratio from the select bits
	function automatic logic [4:0] div_ratio(input logic div8, input logic [1:0] sel);
		logic [4:0] r;
		r = 5'h08;
		if (!div8) begin
			case (sel)
				2'h0:    r = 5'h01;
				2'h1:    r = 5'h02;
				2'h2:    r = 5'h04;
				default: r = 5'h10;
			endcase
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// file: stop_mode_clock_power_ctrl.sv
// stop/wait power mode and cpu clock control with an axi4-lite register port
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module stop_mode_clock_power_ctrl
	import stop_clk_pkg::*;
#(
	parameter int STAB_CYCLES = OSC_STAB_CYCLES
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] s_axi_awaddr,
	input  wire logic       s_axi_awvalid,
	output var  logic       s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0] s_axi_wstrb,
	input  wire logic       s_axi_wvalid,
	output var  logic       s_axi_wready,
	output var  logic [1:0] s_axi_bresp,
	output var  logic       s_axi_bvalid,
	input  wire logic       s_axi_bready,
	input  wire logic [7:0] s_axi_araddr,
	input  wire logic       s_axi_arvalid,
	output var  logic       s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0] s_axi_rresp,
	output var  logic       s_axi_rvalid,
	input  wire logic       s_axi_rready,
	input  wire wake_in_t   wake_pins,
	input  wire logic       timer_event_mode,
	input  wire logic       serial_ext_clk,
	input  wire logic       periph_irq,
	output var  clk_out_t   clk_out,
	output var  pmode_t     mode
);

	localparam logic [15:0] STAB_LAST = 16'(STAB_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// bus channel state
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic [7:0]  wr_addr_reg;
	logic [31:0] wdata_reg;
	logic        wstrb0_reg;

	// control bits
	logic        pclk_off_wait_reg;
	logic        div8_reg;
	logic        div8_next;
	logic        ctrl_b_reg;
	logic [1:0]  div_sel_reg;
	logic        det_en_reg;
	logic        ring_sel_reg;
	logic        action_reg;
	logic        lock_reg;
	logic        pwr_we_reg;

	// mode machine
	pmode_t      mode_reg;
	pmode_t      mode_next;
	logic [15:0] cnt_reg;
	clk_out_t    out_reg;
	clk_out_t    out_next;
	wake_in_t    wake_meta_reg;
	wake_in_t    wake_sync_reg;

	////////////////////////////////////////////////////////////////////////////////
	// write decode: both channels must have been taken before the write lands
	wire wr_fire   = !awready_reg && !wready_reg && !bvalid_reg;
	wire wr_lane   = wr_fire && wstrb0_reg;
	wire wr_ctrl0  = wr_lane && (wr_addr_reg == ADDR_CLK_CTRL0);
	wire wr_ctrl1  = wr_lane && (wr_addr_reg == ADDR_CLK_CTRL1);
	wire wr_ctrl2  = wr_lane && (wr_addr_reg == ADDR_CLK_CTRL2);
	wire wr_pm2    = wr_lane && (wr_addr_reg == ADDR_PROC_MODE2);
	wire wr_prot   = wr_lane && (wr_addr_reg == ADDR_PROTECT);
	wire wr_wait   = wr_lane && (wr_addr_reg == ADDR_WAIT_CMD);
	wire wr_mapped = (wr_addr_reg <= ADDR_POWER_STATUS) && (wr_addr_reg[1:0] == 2'h0);
	wire in_normal = (mode_reg == MODE_NORMAL);
	wire stopped   = (mode_reg == MODE_STOP) || (mode_reg == MODE_RESTART);

	// stop request: ignored under lock and outside normal mode
	wire stop_req  = wr_ctrl1 && wdata_reg[BIT_ALL_OFF] && !lock_reg && in_normal;
	wire wait_req  = wr_wait && wdata_reg[BIT_WAIT] && in_normal;

	// wake qualification: only externally clocked sources can run while stopped
	wire wake_ok   = wake_sync_reg.ext_pin_irq
		|| (wake_sync_reg.timer_irq && timer_event_mode)
		|| (wake_sync_reg.serial_irq && serial_ext_clk);
	wire wait_wake = wake_ok || (periph_irq && !pclk_off_wait_reg);

	// the detector has no main-oscillator failure to see here
	wire osc_stop_seen = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// read decode
	wire [7:0] rd_addr = s_axi_araddr;
	wire rd_mapped = (rd_addr <= ADDR_POWER_STATUS) && (rd_addr[1:0] == 2'h0);
	wire [31:0] rd_ctrl0 = {24'h0, 1'h0, div8_reg, 3'h0, pclk_off_wait_reg, 2'h0};
	wire [31:0] rd_ctrl1 = {24'h0, div_sel_reg, 4'h0, ctrl_b_reg, stopped};
	wire [31:0] rd_ctrl2 = {24'h0, action_reg, 5'h0, ring_sel_reg, det_en_reg};
	wire [31:0] rd_pm2   = {30'h0, lock_reg, 1'h0};
	wire [31:0] rd_prot  = {30'h0, pwr_we_reg, 1'h0};
	wire [31:0] rd_stat  = {29'h0, osc_stop_seen, mode_reg};
	wire [31:0] rd_word  = (rd_addr == ADDR_CLK_CTRL0)  ? rd_ctrl0 :
		(rd_addr == ADDR_CLK_CTRL1)  ? rd_ctrl1 :
		(rd_addr == ADDR_CLK_CTRL2)  ? rd_ctrl2 :
		(rd_addr == ADDR_PROC_MODE2) ? rd_pm2 :
		(rd_addr == ADDR_PROTECT)    ? rd_prot :
		(rd_addr == ADDR_POWER_STATUS) ? rd_stat : 32'h0;

	////////////////////////////////////////////////////////////////////////////////
	// write channels: each ready drops when taken and returns after the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'h1;
			wready_reg  <= 1'h1;
			bvalid_reg  <= 1'h0;
			bresp_reg   <= RESP_OKAY;
			wr_addr_reg <= 8'h00;
			wdata_reg   <= 32'h0;
			wstrb0_reg  <= 1'h0;
		end else begin
			if (awready_reg && s_axi_awvalid) begin
				awready_reg <= 1'h0;
				wr_addr_reg <= s_axi_awaddr;
			end
			if (wready_reg && s_axi_wvalid) begin
				wready_reg <= 1'h0;
				wdata_reg  <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				bvalid_reg <= 1'h1;
				bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'h0;
				awready_reg <= 1'h1;
				wready_reg  <= 1'h1;
			end
		end
	end

	// read channel: one outstanding read, data registered at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'h1;
			rvalid_reg  <= 1'h0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= RESP_OKAY;
		end else if (arready_reg && s_axi_arvalid) begin
			arready_reg <= 1'h0;
			rvalid_reg  <= 1'h1;
			rdata_reg   <= rd_word;
			rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'h0;
			arready_reg <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next values of the select bits, so clk_out moves at the same edge as the register
	wire [1:0] div_sel_next  = wr_ctrl1 ?
		{wdata_reg[BIT_DIV_HI], wdata_reg[BIT_DIV_LO]} : div_sel_reg;
	wire       ring_sel_next = wr_ctrl2 ? wdata_reg[BIT_RING_SEL] : ring_sel_reg;
	wire       pclk_off_next = (wr_ctrl0 && !lock_reg) ?
		wdata_reg[BIT_PCLK_OFF_WAIT] : pclk_off_wait_reg;

	// divide-by-8 is forced on stop entry, so the wake clock is always slow and safe
	assign div8_next = (stop_req || stopped) ? 1'h1 :
		wr_ctrl0 ? wdata_reg[BIT_DIV8] : div8_reg;

	// clock control bits; locked bits keep their value and the write still answers okay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pclk_off_wait_reg <= RST_ZERO;
			div8_reg          <= RST_DIV8;
			ctrl_b_reg        <= RST_ZERO;
			div_sel_reg       <= 2'h0;
			det_en_reg        <= RST_ZERO;
			ring_sel_reg      <= RST_ZERO;
			action_reg        <= RST_ZERO;
		end else begin
			div8_reg <= div8_next;
			if (wr_ctrl0 && !lock_reg) begin
				pclk_off_wait_reg <= pclk_off_next;
			end
			if (wr_ctrl1) begin
				div_sel_reg <= div_sel_next;
				if (!lock_reg) begin
					ctrl_b_reg <= wdata_reg[BIT_CTRL_B];
				end
			end
			if (wr_ctrl2) begin
				ring_sel_reg <= ring_sel_next;
				action_reg   <= wdata_reg[BIT_ACTION];
				if (!lock_reg) begin
					det_en_reg <= wdata_reg[BIT_DET_EN];
				end
			end
		end
	end

	// protection: the lock register only takes writes while write enable is set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_reg   <= RST_ZERO;
			pwr_we_reg <= RST_ZERO;
		end else begin
			if (wr_prot) begin
				pwr_we_reg <= wdata_reg[BIT_PWR_WE];
			end
			if (wr_pm2 && pwr_we_reg) begin
				lock_reg <= wdata_reg[BIT_LOCK];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// wake pins come from clock-stopped peripherals, so they are synchronised first;
	// the bus clock keeps running here, which stands in for the clockless edge catcher
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_meta_reg <= '0;
			wake_sync_reg <= '0;
		end else begin
			wake_meta_reg <= wake_pins;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	// mode machine: stop and wait only from normal, and back only to normal
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			MODE_NORMAL: begin
				if (stop_req) begin
					mode_next = MODE_STOP;
				end else if (wait_req) begin
					mode_next = MODE_WAIT;
				end
			end
			MODE_STOP: begin
				if (wake_ok) begin
					mode_next = MODE_RESTART;
				end
			end
			MODE_RESTART: begin
				if (cnt_reg == STAB_LAST) begin
					mode_next = MODE_NORMAL;
				end
			end
			MODE_WAIT: begin
				if (wait_wake) begin
					mode_next = MODE_NORMAL;
				end
			end
			default: mode_next = MODE_NORMAL;
		endcase
	end

	// stabilisation counter runs only while the oscillator restarts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= MODE_NORMAL;
			cnt_reg  <= 16'h0;
		end else begin
			mode_reg <= mode_next;
			cnt_reg  <= (mode_reg == MODE_RESTART) ? cnt_reg + 16'h1 : 16'h0;
		end
	end

	// clock tree controls follow the next mode so they line up with mode_reg
	always_comb begin
		out_next = '0;
		out_next.main_osc_en    = (mode_next != MODE_STOP) &&
			!((mode_next == MODE_RESTART) && ring_sel_next);
		out_next.ring_osc_en    = (mode_next != MODE_STOP) && ring_sel_next;
		out_next.cpu_clk_en     = (mode_next == MODE_NORMAL);
		out_next.periph_clk_en  = (mode_next == MODE_NORMAL) ||
			((mode_next == MODE_WAIT) && !pclk_off_next);
		out_next.cpu_src_ring   = ring_sel_next;
		out_next.cpu_div        = div_ratio(div8_next, div_sel_next);
		out_next.port_hold      = (mode_next == MODE_STOP) || (mode_next == MODE_RESTART);
		out_next.irq_vector_go  = !in_normal && (mode_reg != MODE_STOP) &&
			(mode_next == MODE_NORMAL);
		out_next.osc_stop_reset = osc_stop_seen && det_en_reg && !action_reg;
		out_next.osc_stop_irq   = osc_stop_seen && det_en_reg && action_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_reg <= '0;
			out_reg.main_osc_en   <= 1'h1;
			out_reg.cpu_clk_en    <= 1'h1;
			out_reg.periph_clk_en <= 1'h1;
			out_reg.cpu_div       <= 5'h08;
		end else begin
			out_reg <= out_next;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign clk_out       = out_reg;
	assign mode          = mode_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_stop_write;
		wr_ctrl1 && wdata_reg[BIT_ALL_OFF] && !lock_reg && in_normal;
	endsequence

	sequence s_restart_done;
		(mode_reg == MODE_RESTART) && (cnt_reg == STAB_LAST);
	endsequence

	stop_gates_clk_a: assert property (
		(mode_reg == MODE_STOP) |-> !clk_out.cpu_clk_en && !clk_out.periph_clk_en
			&& !clk_out.main_osc_en && !clk_out.ring_osc_en)
		else $error("clocks running in stop mode");

	stop_entry_a: assert property (
		s_stop_write |=> (mode_reg == MODE_STOP) && div8_reg && (clk_out.cpu_div == 5'h08))
		else $error("stop entry did not stop or force divide by eight");

	wake_qualify_a: assert property (
		(mode_reg == MODE_STOP) && !wake_ok |=> (mode_reg == MODE_STOP))
		else $error("stop left without a qualifying wake");

	restart_hold_a: assert property (
		(mode_reg == MODE_RESTART) && (cnt_reg != STAB_LAST) |=>
			(mode_reg == MODE_RESTART) && !clk_out.cpu_clk_en)
		else $error("cpu clock released before stabilisation");

	wake_vector_a: assert property (
		s_restart_done |=> clk_out.cpu_clk_en && clk_out.irq_vector_go ##1 !clk_out.irq_vector_go)
		else $error("no single vector pulse after restart");

	wake_source_a: assert property (
		s_restart_done |=> (clk_out.cpu_src_ring == $past(ring_sel_reg)) && (clk_out.cpu_div == 5'h08))
		else $error("wake clock source or divider wrong");

	divider_map_a: assert property (
		!div8_reg && (div_sel_reg == 2'h3) && $stable(div_sel_reg) && $stable(div8_reg)
			|-> (clk_out.cpu_div == 5'h10))
		else $error("divider does not follow select bits");

	lock_keeps_a: assert property (
		wr_ctrl1 && lock_reg |=> $stable(ctrl_b_reg) && (mode_reg != MODE_STOP))
		else $error("locked clock bit changed");

	no_direct_hop_a: assert property (
		(mode_reg == MODE_STOP) || (mode_reg == MODE_WAIT) |=>
			(mode_reg != MODE_WAIT) || ($past(mode_reg) == MODE_WAIT))
		else $error("direct transition between stop and wait");

	pins_hold_a: assert property (
		stopped |-> clk_out.port_hold)
		else $error("port pins released while stopped");

	lock_gate_a: assert property (
		wr_pm2 && !pwr_we_reg |=> $stable(lock_reg))
		else $error("lock written without write enable");

	no_osc_stop_a: assert property (
		!clk_out.osc_stop_reset && !clk_out.osc_stop_irq)
		else $error("oscillation stop detector asserted");

endmodule
`default_nettype wire

// file: stop_mode_clock_power_ctrl_tb_top.sv
// self-checking testbench for the stop-mode clock and power controller
`timescale 1ns/1ps
`default_nettype none
module stop_mode_clock_power_ctrl_tb_top;
	import stop_clk_pkg::*;
	localparam int STAB = 3;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	wake_in_t    wake = 3'h0;
	logic        tmr_evt = 1'b0, ser_ext = 1'b0, pirq = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	clk_out_t    co;
	pmode_t      mode;
	int          bad_count = 0;
	int          n_tests = 0;
	int          vec_count = 0;

	// 50 ns clock
	always #25 aclk = ~aclk;

	stop_mode_clock_power_ctrl #(.STAB_CYCLES(STAB)) stop_mode_clock_power_ctrl_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.wake_pins(wake), .timer_event_mode(tmr_evt), .serial_ext_clk(ser_ext),
		.periph_irq(pirq), .clk_out(co), .mode(mode)
	);

	// vector pulses are counted so a missing or doubled pulse shows up
	always @(posedge aclk) begin
		if (co.irq_vector_go === 1'b1)
			vec_count <= vec_count + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("tests=%0d mismatches=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// tasks start and end just after a rising edge; payload held until its ready;
	// bready and rready stay high between calls so back-to-back calls never toggle them
	// twice in one step; a missing answer is left to the watchdog
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
		awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wstrb <= 4'h1;
		wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
	endtask

	// write then read one register, checking response and read-back
	task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		logic [1:0] r;
		logic [31:0] v;
		wr(a, d, r);
		chk(r, RESP_OKAY);
		rd(a, v, r);
		chk(v, {24'h0, exp});
	endtask

	task automatic wait_mode(input pmode_t m, output int n);
		n = 0;
		while (mode !== m && n < 100) begin
			@(posedge aclk);
			n++;
		end
		chk(mode, m);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] v;
		logic [1:0] r;
		chk({awready, wready, arready, bvalid, rvalid}, 5'h1c);
		chk(co.cpu_div, 5'h08);
		chk({co.main_osc_en, co.cpu_src_ring, co.cpu_clk_en}, 3'h5);
		chk(mode, MODE_NORMAL);
		rd(ADDR_CLK_CTRL0, v, r);
		chk(v, 32'h40);
		rd(ADDR_CLK_CTRL1, v, r);
		chk(v, 32'h0);
		rd(8'h1c, v, r);
		chk({r, v}, {RESP_SLVERR, 32'h0});
		wr(8'h1c, 8'hff, r);
		chk(r, RESP_SLVERR);
		$display("test reset done");
	endtask

	// divider table and source select
	task automatic t_div();
		logic [1:0] r;
		logic [4:0] exp [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
		wrc(ADDR_CLK_CTRL0, 8'h00, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CLK_CTRL1, 8'(s << 6), r);
			chk(co.cpu_div, exp[s]);
		end
		wr(ADDR_CLK_CTRL0, 8'h40, r);
		chk(co.cpu_div, 5'h08);
		wr(ADDR_CLK_CTRL2, 8'h02, r);
		chk(co.cpu_src_ring, 1'b1);
		wr(ADDR_CLK_CTRL2, 8'h00, r);
		chk(co.cpu_src_ring, 1'b0);
		$display("test divider done");
	endtask

	// stop entry and wake by each source, from the ring oscillator at divide-by-2
	task automatic t_stop();
		logic [1:0] r;
		logic [31:0] v;
		int n, v0;
		wr(ADDR_CLK_CTRL2, 8'h02, r);
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_CLK_CTRL0, 8'h00, r);
			wr(ADDR_CLK_CTRL1, 8'h40, r);
			chk(co.cpu_div, 5'h02);
			wr(ADDR_CLK_CTRL1, 8'h41, r);
			chk(mode, MODE_STOP);
			chk({co.main_osc_en, co.ring_osc_en, co.cpu_clk_en, co.periph_clk_en}, 4'h0);
			chk(co.port_hold, 1'b1);
			rd(ADDR_CLK_CTRL0, v, r);
			chk(v, 32'h40);
			rd(ADDR_POWER_STATUS, v, r);
			chk(v, 32'h1);
			// unqualified requests must leave the device stopped
			wake <= 3'h3;
			pirq <= 1'b1;
			repeat (10) @(posedge aclk);
			chk(mode, MODE_STOP);
			chk(co.port_hold, 1'b1);
			wake <= 3'h0;
			pirq <= 1'b0;
			// qualifiers rise only once the old requests have left the synchroniser
			repeat (3) @(posedge aclk);
			tmr_evt <= 1'b1;
			ser_ext <= 1'b1;
			v0 = vec_count;
			wake <= 3'(4 >> s);
			wait_mode(MODE_RESTART, n);
			chk({co.ring_osc_en, co.cpu_clk_en}, 2'h2);
			wait_mode(MODE_NORMAL, n);
			chk(n, STAB);
			@(posedge aclk);
			chk(co.cpu_clk_en, 1'b1);
			chk(vec_count - v0, 32'h1);
			chk({co.cpu_src_ring, co.cpu_div}, {1'b1, 5'h08});
			chk(co.port_hold, 1'b0);
			chk({co.osc_stop_reset, co.osc_stop_irq}, 2'h0);
			wake <= 3'h0;
			tmr_evt <= 1'b0;
			ser_ext <= 1'b0;
		end
		wr(ADDR_CLK_CTRL0, 8'h40, r);
		wr(ADDR_CLK_CTRL2, 8'h00, r);
		$display("test stop done");
	endtask

	// clock lock and its write enable
	task automatic t_lock();
		logic [1:0] r;
		wrc(ADDR_PROC_MODE2, 8'h02, 8'h00);
		wr(ADDR_PROTECT, 8'h02, r);
		wrc(ADDR_PROC_MODE2, 8'h02, 8'h02);
		wr(ADDR_PROTECT, 8'h00, r);
		wrc(ADDR_CLK_CTRL1, 8'h03, 8'h00);
		chk(mode, MODE_NORMAL);
		wrc(ADDR_CLK_CTRL0, 8'h04, 8'h00);
		wrc(ADDR_CLK_CTRL2, 8'h81, 8'h80);
		wr(ADDR_PROTECT, 8'h02, r);
		wrc(ADDR_PROC_MODE2, 8'h00, 8'h00);
		wr(ADDR_PROTECT, 8'h00, r);
		wrc(ADDR_CLK_CTRL2, 8'h00, 8'h00);
		wrc(ADDR_CLK_CTRL0, 8'h40, 8'h40);
		$display("test lock done");
	endtask

	// wait mode with peripheral clocks off, then on
	task automatic t_wait();
		logic [1:0] r;
		int n, v0;
		wr(ADDR_CLK_CTRL0, 8'h44, r);
		wr(ADDR_WAIT_CMD, 8'h01, r);
		chk(mode, MODE_WAIT);
		chk({co.cpu_clk_en, co.periph_clk_en}, 2'h0);
		wr(ADDR_CLK_CTRL1, 8'h01, r);
		chk(mode, MODE_WAIT);
		pirq <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(mode, MODE_WAIT);
		pirq <= 1'b0;
		wr(ADDR_CLK_CTRL0, 8'h40, r);
		chk(co.periph_clk_en, 1'b1);
		v0 = vec_count;
		pirq <= 1'b1;
		wait_mode(MODE_NORMAL, n);
		@(posedge aclk);
		pirq <= 1'b0;
		chk(vec_count - v0, 32'h1);
		chk(co.cpu_clk_en, 1'b1);
		$display("test wait done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence, reset held for five cycles
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_div();
		t_stop();
		t_lock();
		t_wait();
		report_and_stop();
	end

	// the tests need well under 3000 cycles
	initial begin
		#(20000 * 50);
		bad_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
